// ### hdl/pwdt_top.v
// programmable watchdog timer: factor register, countdown, reset pulse, indicator
// assumes wr_in is a one-cycle strobe from the host decode, synchronous to clk_in
`timescale 1ns/10ps
`include "pwdt_consts.vh"
module pwdt_top #(
  parameter [31:0] SEC_CYC = `PWDT_TICK_SEC_CYC,
  parameter [31:0] BLINK_CYC = `PWDT_BLINK_CYC
) (
  input wire clk_in,
  input wire rst_in,
  input wire wr_in,
  input wire [7:0] factor_in,
  input wire minutes_in,
  output reg sys_reset_out,
  output reg armed_out,
  output reg watchdog_activity_indicator_out,
  output reg [7:0] count_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_COUNT = 2'b01;
  localparam [1:0] ST_FIRE = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg base_q;
  reg [4:0] pulse_q;
  reg [4:0] pulse_d;
  reg [31:0] blink_q;
  reg [31:0] blink_d;
  reg ind_d;
  reg sys_reset_d;
  reg armed_d;
  wire tick;
  wire presc_run;
  wire write_zero;
  wire write_load;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 00 is the disarm code; any other factor arms or retriggers, except while the reset pulse runs
  function is_off;
    input [7:0] factor;
    begin
      is_off = (factor == `PWDT_FACTOR_OFF);
    end
  endfunction

  // the unit whose tick ends the period
  function last_unit;
    input [7:0] count;
    begin
      last_unit = (count == `PWDT_COUNT_LAST);
    end
  endfunction

  assign write_zero = wr_in && is_off(factor_in);
  assign write_load = wr_in && !is_off(factor_in);
  // idle prescaler outside the countdown, so an arm starts a full unit
  assign presc_run = (state_q == ST_COUNT);

  // ----------------------------------------
  // time base
  // ----------------------------------------
  // prescaler cleared per write
  pwdt_prescaler #(
    .SEC_CYC(SEC_CYC)
  ) u_pwdt_prescaler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(presc_run),
    // writes clear it, so every retrigger buys a full unit
    .clear_in(wr_in),
    .minutes_in(base_q),
    .tick_out(tick)
  );

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      ST_IDLE: begin
        if (write_load) begin
          state_d = ST_COUNT;
          count_d = factor_in;
        end
      end
      ST_COUNT: begin
        // a disarm beats a reload, and a reload beats a tick
        if (write_zero) begin
          state_d = ST_IDLE;
          count_d = 8'h00;
        end else if (write_load) begin
          count_d = factor_in;
        end else if (tick) begin
          if (last_unit(count_q)) begin
            state_d = ST_FIRE;
            count_d = 8'h00;
          end else begin
            count_d = count_q - 8'h01;
          end
        end
      end
      ST_FIRE: begin
        // pulse runs to full length; the system reset will follow anyway
        if (pulse_q == `PWDT_RST_PULSE_LAST) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        count_d = 8'h00;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      count_q <= 8'h00;
      base_q <= `PWDT_BASE_SEC;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      if (wr_in) begin
        base_q <= minutes_in;
      end
    end
  end

  // ----------------------------------------
  // reset pulse
  // ----------------------------------------
  // pulse length counter
  always @* begin
    if (state_q == ST_FIRE) begin
      pulse_d = pulse_q + 5'h01;
    end else begin
      pulse_d = 5'h00;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      pulse_q <= 5'h00;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  // ----------------------------------------
  // indicator
  // ----------------------------------------
  // blink while armed
  // phase runs on across retriggers; a disarm or an expiry restarts it
  always @* begin
    blink_d = blink_q;
    ind_d = watchdog_activity_indicator_out;
    if (state_d != ST_COUNT) begin
      blink_d = 32'h0000_0000;
      ind_d = 1'b0;
    end else if (blink_q == BLINK_CYC - 32'h0000_0001) begin
      blink_d = 32'h0000_0000;
      ind_d = ~watchdog_activity_indicator_out;
    end else begin
      blink_d = blink_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // outputs look one state ahead so each stands in a flip-flop
  always @* begin
    sys_reset_d = (state_d == ST_FIRE);
    armed_d = (state_d == ST_COUNT);
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      sys_reset_out <= 1'b0;
      armed_out <= 1'b0;
      count_out <= 8'h00;
      blink_q <= 32'h0000_0000;
      watchdog_activity_indicator_out <= 1'b0;
    end else begin
      sys_reset_out <= sys_reset_d;
      armed_out <= armed_d;
      count_out <= count_d;
      blink_q <= blink_d;
      watchdog_activity_indicator_out <= ind_d;
    end
  end
endmodule // pwdt_top

// ### hdl/pwdt_consts.vh
// constants for the programmable watchdog timer
// assumes a 200 MHz clk_in; the tick and blink cycle counts follow from that clock
`ifndef PWDT_CONSTS_VH
`define PWDT_CONSTS_VH
`define PWDT_CLK_HZ 32'h0BEB_C200
`define PWDT_UNIT_SEC 32'h0000_0001
`define PWDT_SEC_PER_MIN 6'h3C
`define PWDT_MIN_LAST_SEC 6'h3B
`define PWDT_TICK_SEC_CYC (`PWDT_CLK_HZ * `PWDT_UNIT_SEC)
`define PWDT_BLINK_CYC (`PWDT_CLK_HZ / 32'h0000_0004)
`define PWDT_RST_PULSE_CYC 8'h10
`define PWDT_RST_PULSE_LAST 5'h0F
`define PWDT_COUNT_LAST 8'h01
`define PWDT_FACTOR_OFF 8'h00
`define PWDT_BASE_SEC 1'b0
`define PWDT_BASE_MIN 1'b1
`endif

// ### hdl/pwdt_prescaler.v
// time-base prescaler: one-cycle tick per second or per minute
// assumes clear_in pulses on every write so a period always starts fresh
`timescale 1ns/10ps
`include "pwdt_consts.vh"
module pwdt_prescaler #(
  parameter [31:0] SEC_CYC = `PWDT_TICK_SEC_CYC
) (
  input wire clk_in,
  input wire rst_in,
  input wire run_in,
  input wire clear_in,
  input wire minutes_in,
  output reg tick_out
);
  reg [31:0] cyc_q;
  reg [5:0] sec_q;
  wire sec_end = (cyc_q == SEC_CYC - 32'h0000_0001);
  wire min_end = (sec_q == `PWDT_MIN_LAST_SEC);
  always @(posedge clk_in) begin
    if (rst_in || clear_in || !run_in) begin
      cyc_q <= 32'h0000_0000;
      sec_q <= 6'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (sec_end) begin
        cyc_q <= 32'h0000_0000;
        if (!minutes_in) begin
          tick_out <= 1'b1;
        end else if (min_end) begin
          sec_q <= 6'h00;
          tick_out <= 1'b1;
        end else begin
          sec_q <= sec_q + 6'h01;
        end
      end else begin
        cyc_q <= cyc_q + 32'h0000_0001;
      end
    end
  end
endmodule // pwdt_prescaler

// ### dv/pwdt_props.sv
// checker on the pwdt_top ports
// assumes it is bound to every pwdt_top
`timescale 1ns/10ps
module pwdt_props (
  input wire clk_in,
  input wire rst_in,
  input wire wr_in,
  input wire [7:0] factor_in,
  input wire minutes_in,
  input wire sys_reset_out,
  input wire armed_out,
  input wire watchdog_activity_indicator_out,
  input wire [7:0] count_out
);
  wire sr = sys_reset_out;
  wire ar = armed_out;
  wire [7:0] cn = count_out;
  wire ind = watchdog_activity_indicator_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_clear: assert property ($fell(rst_in) |-> !ar && cn == 8'h00)
    else $error("not clear");
  a_arm_load: assert property (wr_in && factor_in != 8'h00 && !sr |=> ar && cn == $past(factor_in))
    else $error("no load");
  a_off_stop: assert property (wr_in && factor_in == 8'h00 |=> !ar)
    else $error("no stop");
  a_pulse_len: assert property ($rose(sr) |-> ##15 sr ##1 !sr)
    else $error("pulse length");
  a_expiry_reset: assert property ($fell(ar) && !$past(wr_in) && !$past(wr_in, 2) && !$past(rst_in) |-> ##[0:1] sr)
    else $error("no reset");
  a_count_step: assert property (ar && $past(ar) && !$past(wr_in) |-> cn == $past(cn) || cn == $past(cn) - 8'h01)
    else $error("bad step");
  a_idle_steady: assert property (!ar && !$past(ar) |-> !ind)
    else $error("idle blink");
  a_armed_blink: assert property ($rose(ar) |-> ##[1:9] $changed(ind))
    else $error("no blink");
endmodule // pwdt_props
bind pwdt_top pwdt_props u_pwdt_props (.*);

// ### dv/pwdt_host.sv
// host model writing the watchdog register
// assumes the bench calls wr_byte after reset
`timescale 1ns/10ps
module pwdt_host (
  input wire clk_in,
  output reg wr_out = 1'b0,
  output reg [7:0] factor_out = 8'hA5,
  output reg minutes_out = 1'b0
);
  task wr_byte(input [7:0] f, input m);
    begin
      @(negedge clk_in);
      wr_out = 1'b1;
      factor_out = f;
      minutes_out = m;
      @(negedge clk_in);
      wr_out = 1'b0;
      // released bus shows the inverse
      factor_out = ~f;
      @(negedge clk_in);
    end
  endtask
endmodule // pwdt_host

// ### dv/pwdt_top_tb.sv
// bench for pwdt_top with a short time base
// assumes the host model and the bound checker
`timescale 1ns/10ps
module pwdt_top_tb;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  wire wr, mn, sr, ar, ind;
  wire [7:0] fa, cn;
  integer n_errors = 0, compares = 0, cyc = 0, n;
  reg ind_seen;
  initial forever #2.5 clk_in = ~clk_in;
  pwdt_host u_pwdt_host (.clk_in(clk_in), .wr_out(wr), .factor_out(fa), .minutes_out(mn));
  pwdt_top #(.SEC_CYC(32'd20), .BLINK_CYC(32'd4)) u_pwdt_top (.clk_in(clk_in), .rst_in(rst_in),
    .wr_in(wr), .factor_in(fa), .minutes_in(mn), .sys_reset_out(sr), .armed_out(ar),
    .watchdog_activity_indicator_out(ind), .count_out(cn));
  task chk(input string s, input [7:0] v, input [7:0] e);
    begin
      compares = compares + 1;
      if (v !== e) n_errors = n_errors + 1;
      if (v !== e) $display("BAD %s exp %h seen %h", s, e, v);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // run takes about 1500 cycles
  always @(negedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 9000) n_errors = n_errors + 1;
    if (cyc == 9000) tally_and_finish;
  end
  task wait_sr(input integer lim);
    for (n = 0; sr !== 1'b1 && n < lim; n = n + 1) @(negedge clk_in);
  endtask
  task t_expire;
    begin
      u_pwdt_host.wr_byte(8'h02, 1'b0);
      chk("count", cn, 8'h02);
      ind_seen = ind;
      repeat (4) @(negedge clk_in);
      chk("blink", ind ^ ind_seen, 8'h01);
      wait_sr(60);
      chk("period", n > 34 && n < 44, 8'h01);
      u_pwdt_host.wr_byte(8'h05, 1'b0);
      repeat (20) @(negedge clk_in);
      chk("armed", ar, 8'h00);
      $display("expire done");
    end
  endtask
  task t_retrig;
    begin
      u_pwdt_host.wr_byte(8'h03, 1'b0);
      repeat (3) begin
        repeat (28) @(negedge clk_in);
        chk("tick", cn, 8'h02);
        u_pwdt_host.wr_byte(8'h03, 1'b0);
        chk("reload", cn, 8'h03);
      end
      u_pwdt_host.wr_byte(8'h01, 1'b0);
      chk("change", cn, 8'h01);
      u_pwdt_host.wr_byte(8'h00, 1'b0);
      wait_sr(60);
      chk("stop", {sr, ar, ind}, 8'h00);
      $display("retrigger done");
    end
  endtask
  task t_reset;
    begin
      u_pwdt_host.wr_byte(8'h02, 1'b0);
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      chk("rst count", cn, 8'h00);
      wait_sr(60);
      chk("rst quiet", {sr, ar, ind}, 8'h00);
      $display("reset done");
    end
  endtask
  task t_minutes;
    begin
      u_pwdt_host.wr_byte(8'h01, 1'b1);
      wait_sr(1300);
      chk("minute", n > 1190 && n < 1204, 8'h01);
      repeat (20) @(negedge clk_in);
      u_pwdt_host.wr_byte(8'hFF, 1'b0);
      chk("max", cn, 8'hFF);
      $display("minutes done");
    end
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk("reset", cn | {sr, ar, ind}, 8'h00);
    t_expire;
    t_retrig;
    t_reset;
    t_minutes;
    tally_and_finish;
  end
endmodule // pwdt_top_tb
